// ---- tws_port.sv ----
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tws_consts.svh"
module tws_port #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	output logic strobe_out,
	output logic strobe_out_oe,
	input wire logic busy_in,
	output logic busy_in_func,
	output logic data_in_func,
	output logic transfer_done_irq
);
	tws_pkg::tws_mode_type mode_q, mode_d;
	tws_pkg::tws_cfg_type cfg_q, cfg_d;
	tws_pkg::tws_state_type state_q, state_d;
	logic [AW-1:0] endpt_q, endpt_d, addr_q, addr_d;
	logic [5:0] intvl_q, intvl_d;
	logic [7:0] div_q, div_d, div_cnt_q, div_cnt_d, sr_q, sr_d;
	logic [3:0] bitcnt_q, bitcnt_d;
	logic [15:0] gap_q, gap_d;
	logic tip_q, tip_d, flag_q, flag_d, irq_q, irq_d, stop_q, stop_d;
	logic sck_q, sck_d, sdo_q, sdo_d, rxb_q, rxb_d, stb_q, stb_d;
	logic sck_oe_q, sck_oe_d, sdo_oe_q, sdo_oe_d, stb_oe_q, stb_oe_d;
	logic busyf_q, busyf_d, dinf_q, dinf_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d, ramwait_q, ramwait_d;
	logic [31:0] prdata_q, prdata_d;
	logic sck_s1_q, sck_s2_q, sck_s3_q, sdi_s1_q, sdi_s2_q, busy_s1_q, busy_s2_q;
	logic ram_en, ram_we;
	logic [AW-1:0] ram_addr;
	logic [7:0] ram_wdata, ram_rdata;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	tws_buf_ram #(.DEPTH(DEPTH), .AW(AW), .DW(8)) u_ram (
		.clk(pclk),
		.rst_n(presetn),
		.en(ram_en),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// pin synchronisers; stage one feeds stage two, and the clock pin has a third stage for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_s3_q <= 1'b1;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= serial_clock_pin_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			sdi_s1_q <= serial_data_in;
			sdi_s2_q <= sdi_s1_q;
			busy_s1_q <= busy_in;
			busy_s2_q <= busy_s1_q;
		end
	end

	logic acc, done, is_ram, mapped, cpu_rd, cpu_wr, eng_free, tick, fall_ev, rise_ev;
	logic strobe_func, last;
	logic [5:0] periods;
	logic [9:0] period;
	logic [7:0] rdmux;

	always_comb begin
		mode_d = mode_q;
		cfg_d = cfg_q;
		state_d = state_q;
		endpt_d = endpt_q;
		addr_d = addr_q;
		intvl_d = intvl_q;
		div_d = div_q;
		div_cnt_d = '0;
		sr_d = sr_q;
		bitcnt_d = bitcnt_q;
		gap_d = gap_q;
		tip_d = tip_q;
		flag_d = flag_q;
		irq_d = 1'b0;
		stop_d = stop_q;
		sck_d = 1'b1;
		sdo_d = sdo_q;
		rxb_d = rxb_q;
		stb_d = stb_q;
		ramwait_d = ramwait_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		ram_en = 1'b0;
		ram_we = 1'b0;
		ram_addr = addr_q;
		ram_wdata = mode_q.bit_order_select ? rev8(sr_q) : sr_q;

		// apb: one wait state for registers, two for buffer reads
		acc = psel && penable;
		done = acc && pready_q;
		is_ram = paddr[`TWS_RAM_SEL] && (paddr[1:0] == 2'b00);
		cpu_rd = acc && !pready_q && !pwrite && is_ram && !ramwait_q;
		cpu_wr = done && pwrite && is_ram;
		eng_free = !(cpu_rd || cpu_wr);
		mapped = 1'b1;
		rdmux = 8'h00;
		case (paddr)
			`TWS_OFS_MODE: rdmux = mode_q;
			`TWS_OFS_STAT: rdmux = {2'b00, cfg_q.strobe_enable, cfg_q.busy_enable, 1'b0,
				cfg_q.error_check_enable, 1'b0, tip_q};
			`TWS_OFS_TRIG: rdmux = 8'h00;
			`TWS_OFS_SHIFT: rdmux = mode_q.bit_order_select ? rev8(sr_q) : sr_q;
			`TWS_OFS_ENDPT: rdmux = 8'(endpt_q);
			`TWS_OFS_INTVL: rdmux = {2'b00, intvl_q};
			`TWS_OFS_ADDR: rdmux = 8'(addr_q);
			`TWS_OFS_DIV: rdmux = div_q;
			`TWS_OFS_FLAG: rdmux = {7'h00, flag_q};
			default: mapped = is_ram;
		endcase
		if (cpu_rd || cpu_wr) begin
			ram_en = 1'b1;
			ram_we = cpu_wr;
			ram_addr = paddr[AW+1:2];
			ram_wdata = pwdata[7:0];
		end
		if (cpu_rd) begin
			ramwait_d = 1'b1;
		end
		if (acc && !pready_q) begin
			if (!mapped) begin
				pready_d = 1'b1;
				pslverr_d = 1'b1;
				prdata_d = '0;
			end else if (is_ram && !pwrite) begin
				if (ramwait_q) begin
					pready_d = 1'b1;
					ramwait_d = 1'b0;
					prdata_d = {24'h000000, ram_rdata};
				end
			end else begin
				pready_d = 1'b1;
				prdata_d = {24'h000000, rdmux};
			end
		end

		// serial clock events: own divider in master role, pin edges in slave role
		period = 10'(({2'b00, div_q} + 10'h001) << 1);
		tick = (div_cnt_q == div_q);
		if (mode_q.master_role_select) begin
			fall_ev = (state_q == tws_pkg::st_shift) && tick && sck_q;
			rise_ev = (state_q == tws_pkg::st_shift) && tick && !sck_q;
		end else begin
			fall_ev = (state_q == tws_pkg::st_shift) && sck_s3_q && !sck_s2_q;
			rise_ev = (state_q == tws_pkg::st_shift) && !sck_s3_q && sck_s2_q;
		end
		strobe_func = mode_q.master_role_select && cfg_q.strobe_enable && cfg_q.busy_enable;
		periods = intvl_q;
		if (cfg_q.strobe_enable && periods < `TWS_STB_MIN) begin
			periods = `TWS_STB_MIN;
		end else if (cfg_q.busy_enable && periods < `TWS_BUSY_MIN) begin
			periods = `TWS_BUSY_MIN;
		end
		last = (addr_q == endpt_q);

		case (state_q)
			tws_pkg::st_fetch: begin
				if (eng_free) begin
					ram_en = 1'b1;
					ram_addr = addr_q;
					state_d = tws_pkg::st_load;
				end
			end
			tws_pkg::st_load: begin
				sr_d = mode_q.bit_order_select ? rev8(ram_rdata) : ram_rdata;
				bitcnt_d = '0;
				state_d = tws_pkg::st_shift;
			end
			tws_pkg::st_shift: begin
				// slave role keeps the driven clock parked high
				sck_d = (tick && mode_q.master_role_select) ? !sck_q : sck_q;
				div_cnt_d = tick ? 8'h00 : 8'(div_cnt_q + 8'h01);
				if (fall_ev) begin
					sdo_d = mode_q.transmit_enable && sr_q[7];
					rxb_d = sdi_s2_q;
				end
				if (rise_ev) begin
					sr_d = {sr_q[6:0], rxb_q};
					bitcnt_d = 4'(bitcnt_q + 4'h1);
					if (bitcnt_q == `TWS_LAST_BIT) begin
						sck_d = 1'b1;
						if (!mode_q.auto_mode_select) begin
							state_d = tws_pkg::st_idle;
							tip_d = 1'b0;
							flag_d = 1'b1;
							irq_d = 1'b1;
						end else begin
							state_d = tws_pkg::st_store;
						end
					end
				end
			end
			tws_pkg::st_store: begin
				if (eng_free) begin
					ram_en = mode_q.receive_enable;
					ram_we = mode_q.receive_enable;
					ram_addr = addr_q;
					if (stop_q || (last && !mode_q.repeat_mode_select)) begin
						state_d = tws_pkg::st_idle;
						tip_d = 1'b0;
						stop_d = 1'b0;
						flag_d = 1'b1;
						irq_d = 1'b1;
					end else begin
						addr_d = last ? '0 : AW'(addr_q + 1'b1);
						if (strobe_func) begin
							state_d = tws_pkg::st_strobe;
							stb_d = 1'b1;
							gap_d = 16'(period - 10'h001);
						end else begin
							state_d = tws_pkg::st_gap;
							gap_d = 16'(16'(period) * 16'(periods));
						end
					end
				end
			end
			tws_pkg::st_strobe: begin
				if (gap_q != 16'h0000) begin
					gap_d = 16'(gap_q - 16'h0001);
				end else begin
					stb_d = 1'b0;
					state_d = tws_pkg::st_gap;
					gap_d = 16'(16'(period) * 16'(periods - 6'h01));
				end
			end
			tws_pkg::st_gap: begin
				if (gap_q != 16'h0000) begin
					gap_d = 16'(gap_q - 16'h0001);
				end else if (!(strobe_func && busy_s2_q)) begin
					state_d = tws_pkg::st_fetch;
				end
			end
			default: begin
				state_d = tws_pkg::st_idle;
			end
		endcase

		// register writes take effect at the completing edge
		if (done && pwrite && !is_ram) begin
			case (paddr)
				`TWS_OFS_MODE: mode_d = tws_pkg::tws_mode_type'({pwdata[7:1], 1'b0});
				`TWS_OFS_STAT: begin
					cfg_d.strobe_enable = pwdata[`TWS_STAT_STBE];
					cfg_d.busy_enable = pwdata[`TWS_STAT_BUSYE];
					cfg_d.error_check_enable = pwdata[`TWS_STAT_ERRE];
				end
				`TWS_OFS_TRIG: begin
					if (pwdata[`TWS_TRIG_START] && mode_q.port_enable && mode_q.auto_mode_select
						&& !tip_q) begin
						addr_d = '0;
						tip_d = 1'b1;
						stop_d = 1'b0;
						state_d = tws_pkg::st_fetch;
					end
					if (pwdata[`TWS_TRIG_STOP] && tip_q) begin
						stop_d = 1'b1;
					end
				end
				`TWS_OFS_SHIFT: begin
					if (!tip_q) begin
						sr_d = mode_q.bit_order_select ? rev8(pwdata[7:0]) : pwdata[7:0];
						if (mode_q.port_enable && !mode_q.auto_mode_select) begin
							tip_d = 1'b1;
							sdo_d = 1'b0;
							bitcnt_d = '0;
							state_d = tws_pkg::st_shift;
						end
					end
				end
				`TWS_OFS_ENDPT: endpt_d = pwdata[AW-1:0];
				`TWS_OFS_INTVL: intvl_d = pwdata[5:0];
				`TWS_OFS_DIV: div_d = pwdata[7:0];
				`TWS_OFS_FLAG: begin
					if (pwdata[`TWS_FLAG_DONE] && !irq_d) begin
						flag_d = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// disabled port holds state, tip, stop, address, bit count, gap, data and strobe pins and irq cleared and the clock pin high; other registers keep their values
		if (!mode_q.port_enable) begin
			state_d = tws_pkg::st_idle;
			tip_d = 1'b0;
			stop_d = 1'b0;
			addr_d = '0;
			bitcnt_d = '0;
			gap_d = '0;
			stb_d = 1'b0;
			sdo_d = 1'b0;
			sck_d = 1'b1;
			irq_d = 1'b0;
		end
		sck_oe_d = mode_q.port_enable && mode_q.master_role_select;
		sdo_oe_d = mode_q.port_enable && mode_q.transmit_enable;
		stb_oe_d = mode_q.port_enable && mode_q.auto_mode_select && strobe_func;
		busyf_d = mode_q.port_enable && mode_q.auto_mode_select && strobe_func;
		dinf_d = mode_q.port_enable && mode_q.receive_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `TWS_MODE_RST;
			cfg_q <= '0;
			state_q <= tws_pkg::st_idle;
			endpt_q <= `TWS_ENDPT_RST;
			addr_q <= '0;
			intvl_q <= `TWS_INTVL_RST;
			div_q <= `TWS_DIV_RST;
			div_cnt_q <= '0;
			sr_q <= '0;
			bitcnt_q <= '0;
			gap_q <= '0;
			tip_q <= 1'b0;
			flag_q <= 1'b0;
			irq_q <= 1'b0;
			stop_q <= 1'b0;
			sck_q <= 1'b1;
			sdo_q <= 1'b0;
			rxb_q <= 1'b0;
			stb_q <= 1'b0;
			sck_oe_q <= 1'b0;
			sdo_oe_q <= 1'b0;
			stb_oe_q <= 1'b0;
			busyf_q <= 1'b0;
			dinf_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			ramwait_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			mode_q <= mode_d;
			cfg_q <= cfg_d;
			state_q <= state_d;
			endpt_q <= endpt_d;
			addr_q <= addr_d;
			intvl_q <= intvl_d;
			div_q <= div_d;
			div_cnt_q <= div_cnt_d;
			sr_q <= sr_d;
			bitcnt_q <= bitcnt_d;
			gap_q <= gap_d;
			tip_q <= tip_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
			stop_q <= stop_d;
			sck_q <= sck_d;
			sdo_q <= sdo_d;
			rxb_q <= rxb_d;
			stb_q <= stb_d;
			sck_oe_q <= sck_oe_d;
			sdo_oe_q <= sdo_oe_d;
			stb_oe_q <= stb_oe_d;
			busyf_q <= busyf_d;
			dinf_q <= dinf_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			ramwait_q <= ramwait_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign serial_clock_pin_out = sck_q;
	assign serial_clock_pin_oe = sck_oe_q;
	assign serial_data_out = sdo_q;
	assign serial_data_out_oe = sdo_oe_q;
	assign strobe_out = stb_q;
	assign strobe_out_oe = stb_oe_q;
	assign busy_in_func = busyf_q;
	assign data_in_func = dinf_q;
	assign transfer_done_irq = irq_q;
endmodule // tws_port
`default_nettype wire

// ---- tws_consts.svh ----
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_OFS_MODE 8'h00
`define TWS_OFS_STAT 8'h04
`define TWS_OFS_TRIG 8'h08
`define TWS_OFS_SHIFT 8'h0c
`define TWS_OFS_ENDPT 8'h10
`define TWS_OFS_INTVL 8'h14
`define TWS_OFS_ADDR 8'h18
`define TWS_OFS_DIV 8'h1c
`define TWS_OFS_FLAG 8'h20
`define TWS_RAM_SEL 7
`define TWS_STAT_STBE 5
`define TWS_STAT_BUSYE 4
`define TWS_STAT_ERRE 2
`define TWS_STAT_TSF 0
`define TWS_TRIG_START 0
`define TWS_TRIG_STOP 1
`define TWS_FLAG_DONE 0
`define TWS_MODE_RST 8'h00
`define TWS_DIV_RST 8'h00
`define TWS_ENDPT_RST 5'h00
`define TWS_INTVL_RST 6'h00
`define TWS_LAST_BIT 4'h7
`define TWS_STB_MIN 6'h02
`define TWS_BUSY_MIN 6'h01
`endif

// ---- tws_pkg.sv ----
package tws_pkg;
	typedef struct packed {
		logic port_enable;
		logic auto_mode_select;
		logic repeat_mode_select;
		logic master_role_select;
		logic transmit_enable;
		logic receive_enable;
		logic bit_order_select;
		logic unused0;
	} tws_mode_type;
	typedef struct packed {
		logic strobe_enable;
		logic busy_enable;
		logic error_check_enable;
	} tws_cfg_type;
	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_fetch = 7'h02,
		st_load = 7'h04,
		st_shift = 7'h08,
		st_store = 7'h10,
		st_strobe = 7'h20,
		st_gap = 7'h40
	} tws_state_type;
endpackage

// ---- tws_buf_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_buf_ram #(
	parameter int DEPTH = 32,
	parameter int AW = 5,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rdata_q;
	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (en && !we) begin
			rdata_q <= mem[addr];
		end
	end
	assign rdata = rdata_q;
endmodule // tws_buf_ram
`default_nettype wire

// ---- tws_port_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_port_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic strobe_out,
	input wire logic strobe_out_oe,
	input wire logic busy_in_func,
	input wire logic transfer_done_irq
);
	logic sck_q;
	logic [2:0] falls_q;
	logic [2:0] falls_d;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence clk_parked;
		serial_clock_pin_out [*3];
	endsequence
	// falls of the driven clock, modulo one byte
	always_comb begin
		falls_d = falls_q;
		if (!serial_clock_pin_oe) begin
			falls_d = 3'h0;
		end else if (sck_q && !serial_clock_pin_out) begin
			falls_d = falls_q + 3'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q <= 1'b1;
			falls_q <= 3'h0;
		end else begin
			sck_q <= serial_clock_pin_out;
			falls_q <= falls_d;
		end
	end
	apb_answer_a: assert property ($rose(penable) && psel |-> ##[1:4] pready)
		else $error("apb access not answered");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	pin_func_a: assert property (strobe_out_oe == busy_in_func)
		else $error("strobe and busy pin roles differ");
	strobe_gate_a: assert property (strobe_out |-> strobe_out_oe)
		else $error("strobe without strobe role");
	clk_idle_a: assert property (!serial_clock_pin_oe |-> serial_clock_pin_out)
		else $error("serial clock low while not driven");
	irq_pulse_a: assert property (transfer_done_irq |=> !transfer_done_irq)
		else $error("done pulse too long");
	irq_park_a: assert property (transfer_done_irq |-> clk_parked)
		else $error("clock not parked after byte");
	byte_bits_a: assert property (transfer_done_irq |-> falls_q == 3'h0)
		else $error("byte not eight clocks");
	half_period_a: assert property ($fell(serial_clock_pin_out) |-> ##[1:256]
		$rose(serial_clock_pin_out))
		else $error("serial clock stuck low");
	data_edge_a: assert property ($changed(serial_data_out) && serial_data_out_oe
		&& $past(serial_data_out_oe) && serial_clock_pin_oe
		|-> $fell(serial_clock_pin_out) || $past(psel && penable && pready && pwrite))
		else $error("data out changed off a falling edge");
endmodule // tws_port_sva
bind tws_port tws_port_sva i_tws_port_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_out,
	.serial_data_out_oe, .strobe_out, .strobe_out_oe, .busy_in_func, .transfer_done_irq);
`default_nettype wire

// ---- tws_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
	input wire logic rst_n,
	input wire logic sck,
	input wire logic sdo,
	input wire logic [7:0] tx,
	output logic sdi,
	output logic [7:0] rx
);
	logic [2:0] cnt;
	logic [7:0] sh;
	// bit changes after each rise, stable at the fall
	assign sdi = tx[3'h7 - cnt];
	always @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
			sh <= 8'h00;
			rx <= 8'h00;
		end else begin
			sh <= {sh[6:0], sdo};
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7) begin
				rx <= {sh[6:0], sdo};
			end
		end
	end
endmodule // tws_peer
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, o, r;
	logic [7:0] paddr, ptx, prx, d, t;
	logic [31:0] pwdata, prdata, q;
	logic sck_out, sck_oe, sdo, sdo_oe, sdi, stb, stb_oe, busy, bfunc, dfunc, irq, stb_seen;
	logic [7:0] bq [32];
	int fails, tests_run, cyc, irqs, seed, i, k, nb;
	wire sck_w = sck_oe ? sck_out : 1'b1;
	tws_port i_tws_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_clock_pin_in(sck_w),
		.serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .strobe_out(stb),
		.strobe_out_oe(stb_oe), .busy_in(busy), .busy_in_func(bfunc),
		.data_in_func(dfunc), .transfer_done_irq(irq));
	tws_peer i_peer (.rst_n(presetn), .sck(sck_w), .sdo, .tx(ptx), .sdi, .rx(prx));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		busy <= ($random(seed) & 3) == 0;
		if (irq === 1'b1) begin
			irqs <= irqs + 1;
		end
		if (stb === 1'b1) begin
			stb_seen <= 1'b1;
		end
		if (cyc == 60000) begin
			fails++;
			tally_and_finish;
		end
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			$display("wrong value %s expected %h seen %h", n, x, g);
			fails++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input string n, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, x, q);
	endtask
	task wirq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 9000) begin
			@(posedge pclk);
			n++;
		end
		chk("done irq", 1, irq);
	endtask
	function logic [7:0] rev8(input logic [7:0] v);
		for (int j = 0; j < 8; j++) begin
			rev8[j] = v[7 - j];
		end
	endfunction
	initial begin
		seed = 32'hc24635e7;
		{psel, penable, pwrite, busy, stb_seen} = 5'h00;
		{paddr, pwdata, ptx} = 48'h0;
		{fails, tests_run, cyc, irqs} = 128'h0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, "mode", 0);
		apb(1'b0, 8'h24, 0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, q);
		apb(1'b1, 8'h1c, 3);
		apb(1'b1, 8'h0c, 8'ha5);
		k = irqs;
		apb(1'b1, 8'h00, 8'h9c);
		repeat (200) @(posedge pclk);
		chk("rx pin role", 1, dfunc);
		chk("clock pin role", 1, sck_oe);
		chk("data pin role", 1, sdo_oe);
		rd(8'h04, "pending write", 0);
		chk("irq count", k, irqs);
		for (i = 0; i < 6; i++) begin
			d = $random(seed);
			t = $random(seed);
			o = $random(seed);
			r = $random(seed);
			ptx <= t;
			apb(1'b1, 8'h00, {24'h0, 2'b10, r, 3'b111, o, 1'b0});
			apb(1'b1, 8'h0c, {24'h0, d});
			rd(8'h04, "in progress", 1);
			apb(1'b1, 8'h0c, {24'h0, ~d});
			wirq;
			chk("peer rx", o ? rev8(d) : d, prx);
			rd(8'h04, "idle", 0);
			rd(8'h0c, "shift", o ? rev8(t) : t);
		end
		nb = 2 + ($random(seed) & 3);
		t = $random(seed);
		ptx <= t;
		for (i = 0; i < nb; i++) begin
			bq[i] = $random(seed);
			apb(1'b1, 8'h80 + 8'(i * 4), {24'h0, bq[i]});
		end
		apb(1'b1, 8'h10, nb - 1);
		apb(1'b1, 8'h04, 8'h30);
		apb(1'b1, 8'h00, 8'hd0);
		apb(1'b1, 8'h00, 8'hdc);
		apb(1'b1, 8'h14, 1);
		chk("strobe pin role", 1, stb_oe);
		chk("busy pin role", 1, bfunc);
		apb(1'b1, 8'h08, 1);
		wirq;
		for (i = 0; i < nb; i++) begin
			rd(8'h80 + 8'(i * 4), "buffer", t);
		end
		chk("peer auto rx", bq[nb - 1], prx);
		chk("strobe seen", 1, stb_seen);
		rd(8'h18, "address", nb - 1);
		rd(8'h04, "auto idle", 8'h30);
		apb(1'b1, 8'h00, 8'h98);
		repeat (2) @(posedge pclk);
		chk("rx pin free", 0, dfunc);
		chk("strobe pin free", 0, stb_oe);
		chk("busy pin free", 0, bfunc);
		apb(1'b1, 8'h00, 8'h9c);
		apb(1'b1, 8'h0c, 8'h3c);
		repeat (20) @(posedge pclk);
		k = irqs;
		apb(1'b1, 8'h00, 0);
		repeat (100) @(posedge pclk);
		chk("abort irq", k, irqs);
		chk("abort clock", 1, sck_out);
		chk("abort data", 0, sdo);
		chk("abort clock role", 0, sck_oe);
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
